/* File: include/trigger_frame_map.svh */
`ifndef TRIGGER_FRAME_MAP_SVH
`define TRIGGER_FRAME_MAP_SVH
`define FRAME_SYMBOLS 24
`define USER_SYMBOLS 20
`define PAYLOAD_BITS 160
`define TRIGGER_TYPE_WORD_LO_BYTE 0
`define TRIGGER_TYPE_WORD_HI_BYTE 1
`define BUNCH_CROSSING_ID_LO_BYTE 2
`define BUNCH_CROSSING_ID_HI_BYTE 3
`define ORBIT_BYTE0 4
`define UPLINK_WORDS 3
`define UPLINK_BITS 48
`define BUSY_WIDTH 16
`define BUSY_DEPTH 8
`define SYS_CLOCK_MHZ 125
`define WAIT_64RX_US 8
`define WAIT_32RX_US 4
`define WAIT_64RX_CYCLES (`WAIT_64RX_US * `SYS_CLOCK_MHZ)
`define WAIT_32RX_CYCLES (`WAIT_32RX_US * `SYS_CLOCK_MHZ)
`endif

/* File: include/trigger_frame_pkg.sv */
package trigger_frame_pkg;
    typedef struct packed {
        logic [15:0] triggerTypeWord;
        logic [11:0] bunchCrossingId;
        logic [31:0] orbitCount;
    } trigger_info_type;
    typedef struct packed {
        logic orbitMarker;
        logic heartbeatAccept;
        logic heartbeatReject;
        logic prepulseFlag;
        logic calibration;
        logic startEnd;
        logic triggeredRunFlag;
        logic continuousRunFlag;
        logic moduleTransferTrigger;
    } trigger_flags_type;
    typedef enum logic [1:0] {
        COLLECT = 2'b00,
        WAIT_SLOT = 2'b01,
        SENDING = 2'b10
    } uplink_state_type;
endpackage : trigger_frame_pkg

/* File: rtl/trigger_frame_decoder.sv */
// Function
// [RULE1] trigger unit sends one 240-bit frame every bunch clock, no gaps
// [RULE2] twenty of 24 symbols form the 160-bit user payload per frame
// [RULE3] trigger-type word: byte 1 gives bits 0-7, byte 2 bits 8-15
// [RULE4] bunch-crossing id: byte 3 bits 0-7, byte 4 low nibble bits 8-11
// [RULE5] orbit counter from bytes 5 to 8, byte 5 least significant
// [RULE6] flags 1-5 exposed: orbit, heartbeat accept/reject, prepulse, calibration
// [RULE7] flag 6 qualifies flags 7 and 8: one starts, zero ends
// [RULE8] flag 7 marks triggered run, flag 8 continuous run
// [RULE9] flag 9 requests module transfer; flags 10-16 spare and ignored
// [RULE10] downlink carries bunch clock, trigger and throttle data
// [RULE11] busy information returns upstream as 48-bit payload
// [RULE12] sender holds busy data through slot wait of 8 or 4 us
// [RULE13] continuous read-out drops only whole heartbeat frames
// [RULE14] decoded trigger presented with a valid strobe
// [RULE15] user writes 16-bit busy words, never while fifo full
// [RULE16] all fields of one frame registered together
`timescale 1ns/10ps
`include "trigger_frame_map.svh"

module busy_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic full, empty, doWrite, doRead;

    always_comb
    begin
        full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
        empty = (wrPtr_q == rdPtr_q);
        inReady = !full;
        outValid = !empty;
        outData = mem[rdPtr_q[AW-1:0]];
        doWrite = inValid && !full;
        doRead = outReady && !empty;
        wrPtr_d = doWrite ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = doRead ? rdPtr_q + 1'b1 : rdPtr_q;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
        if (doWrite)
        begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end
endmodule : busy_fifo

module trigger_frame_decoder
    import trigger_frame_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic linkClock,
    input wire logic linkRst,
    input wire logic frameValid,
    input wire logic [`PAYLOAD_BITS-1:0] framePayload,
    input wire logic uplinkSlot,
    output logic [`UPLINK_BITS-1:0] uplinkWord,
    output logic uplinkLoad,
    output logic frameGap,
    output logic trigValid,
    output trigger_info_type trigInfo,
    output trigger_flags_type trigFlags,
    output logic triggeredRun,
    output logic continuousRun,
    input wire logic dropRequest,
    output logic hbfDrop,
    input wire logic receivers32,
    input wire logic busyWrite,
    input wire logic [`BUSY_WIDTH-1:0] busyData,
    output logic busyFull,
    output logic slotOverdue
);
    // link domain: decode and hold one frame
    trigger_info_type linkInfo_q, linkInfo_d;
    logic frameTog_q, frameTog_d, started_q, started_d, gap_q, gap_d;
    logic slotTog_q, slotTog_d, load_q, load_d;
    logic [`UPLINK_BITS-1:0] upWord_q, upWord_d;
    logic reqS1_q, reqS2_q, reqS3_q;
    // sender words read by the link side, held stable while the request toggle travels
    logic [`UPLINK_BITS-1:0] holdWord_q, holdWord_d;
    logic reqTog_q, reqTog_d;
    logic [7:0] pb [`USER_SYMBOLS];

    for (genvar i = 0; i < `USER_SYMBOLS; i++)
    begin : g_bytes
        assign pb[i] = framePayload[8*i +: 8]; // [RULE2]
    end

    always_comb
    begin
        linkInfo_d = linkInfo_q;
        frameTog_d = frameTog_q;
        started_d = started_q | frameValid;
        gap_d = gap_q | (started_q & ~frameValid); // [RULE1]
        slotTog_d = slotTog_q ^ uplinkSlot;
        load_d = reqS2_q ^ reqS3_q;
        upWord_d = upWord_q;
        if (frameValid)
        begin
            linkInfo_d.triggerTypeWord = {pb[`TRIGGER_TYPE_WORD_HI_BYTE], pb[`TRIGGER_TYPE_WORD_LO_BYTE]}; // [RULE3]
            linkInfo_d.bunchCrossingId = {pb[`BUNCH_CROSSING_ID_HI_BYTE][3:0], pb[`BUNCH_CROSSING_ID_LO_BYTE]}; // [RULE4]
            linkInfo_d.orbitCount = {pb[`ORBIT_BYTE0+3], pb[`ORBIT_BYTE0+2],
                pb[`ORBIT_BYTE0+1], pb[`ORBIT_BYTE0]}; // [RULE5]
            frameTog_d = ~frameTog_q;
        end
        if (load_d)
        begin
            upWord_d = holdWord_q; // [RULE11]
        end
    end

    always_ff @(posedge linkClock)
    begin
        if (linkRst)
        begin
            linkInfo_q <= '0;
            frameTog_q <= 1'b0;
            started_q <= 1'b0;
            gap_q <= 1'b0;
            slotTog_q <= 1'b0;
            load_q <= 1'b0;
            upWord_q <= '0;
            reqS1_q <= 1'b0;
            reqS2_q <= 1'b0;
            reqS3_q <= 1'b0;
        end
        else
        begin
            linkInfo_q <= linkInfo_d; // [RULE16]
            frameTog_q <= frameTog_d;
            started_q <= started_d;
            gap_q <= gap_d;
            slotTog_q <= slotTog_d;
            load_q <= load_d;
            upWord_q <= upWord_d;
            reqS1_q <= reqTog_q;
            reqS2_q <= reqS1_q;
            reqS3_q <= reqS2_q;
        end
    end

    assign uplinkWord = upWord_q;
    assign uplinkLoad = load_q;

    // system domain
    logic frS1_q, frS2_q, frS3_q, slS1_q, slS2_q, slS3_q, gpS1_q, gpS2_q;
    logic ackS1_q, ackS2_q, ackS3_q;
    logic newFrame, slotSeen, ackSeen;
    logic trigValid_q, trigValid_d, trun_q, trun_d, crun_q, crun_d, drop_q, drop_d;
    trigger_info_type info_q, info_d;
    trigger_flags_type flags_q, flags_d;
    logic [15:0] tt;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            {frS1_q, frS2_q, frS3_q, slS1_q, slS2_q, slS3_q} <= '0;
            {gpS1_q, gpS2_q, ackS1_q, ackS2_q, ackS3_q} <= '0;
        end
        else
        begin
            {frS1_q, frS2_q, frS3_q} <= {frameTog_q, frS1_q, frS2_q};
            {slS1_q, slS2_q, slS3_q} <= {slotTog_q, slS1_q, slS2_q};
            {gpS1_q, gpS2_q} <= {gap_q, gpS1_q};
            {ackS1_q, ackS2_q, ackS3_q} <= {reqS3_q, ackS1_q, ackS2_q};
        end
    end

    // captures linkInfo_q two edges after its toggle is seen; the held
    // word stays stable for a full bunch period, far longer than that
    assign newFrame = frS2_q ^ frS3_q;
    assign slotSeen = slS2_q ^ slS3_q;

    always_comb
    begin
        tt = linkInfo_q.triggerTypeWord & 16'h01ff; // [RULE9]
        info_d = info_q;
        flags_d = flags_q;
        trigValid_d = newFrame; // [RULE14]
        trun_d = trun_q;
        crun_d = crun_q;
        drop_d = drop_q;
        if (newFrame)
        begin
            info_d = linkInfo_q;
            info_d.triggerTypeWord = tt;
            flags_d = {tt[0], tt[1], tt[2], tt[3], tt[4], tt[5], tt[6], tt[7], tt[8]}; // [RULE6]
            if (tt[6])
            begin
                trun_d = tt[5]; // [RULE7] [RULE8]
            end
            if (tt[7])
            begin
                crun_d = tt[5]; // [RULE7] [RULE8]
            end
            if (tt[1] | tt[2])
            begin
                // decision only changes at a heartbeat boundary
                drop_d = crun_d & (dropRequest | tt[2]); // [RULE13]
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            info_q <= '0;
            flags_q <= '0;
            trigValid_q <= 1'b0;
            trun_q <= 1'b0;
            crun_q <= 1'b0;
            drop_q <= 1'b0;
        end
        else
        begin
            info_q <= info_d; // [RULE16]
            flags_q <= flags_d;
            trigValid_q <= trigValid_d;
            trun_q <= trun_d;
            crun_q <= crun_d;
            drop_q <= drop_d;
        end
    end

    assign trigValid = trigValid_q;
    assign trigInfo = info_q;
    assign trigFlags = flags_q;
    assign triggeredRun = trun_q;
    assign continuousRun = crun_q;
    assign hbfDrop = drop_q;
    assign frameGap = gpS2_q;

    // upstream sender
    logic fifoReady, fifoValid, popWord;
    logic [`BUSY_WIDTH-1:0] fifoData;
    uplink_state_type state_q, state_d;
    logic [1:0] count_q, count_d;
    logic full_q, full_d, over_q, over_d;
    logic [3:0] fill_q, fill_d;
    logic [9:0] wait_q, wait_d, waitLimit;

    busy_fifo #(.WIDTH(`BUSY_WIDTH), .DEPTH(`BUSY_DEPTH)) u_fifo
    (
        .clock(clock),
        .srst(srst),
        .inValid(busyWrite),
        .inData(busyData),
        .inReady(fifoReady),
        .outValid(fifoValid),
        .outData(fifoData),
        .outReady(popWord)
    );

    assign ackSeen = ackS2_q ^ ackS3_q;

    always_comb
    begin
        waitLimit = receivers32 ? 10'(`WAIT_32RX_CYCLES) : 10'(`WAIT_64RX_CYCLES);
        state_d = state_q;
        count_d = count_q;
        holdWord_d = holdWord_q;
        reqTog_d = reqTog_q;
        wait_d = wait_q;
        over_d = over_q;
        popWord = (state_q == COLLECT) && fifoValid;
        // fill level kept here so the flag needs no look inside the fifo
        fill_d = fill_q + 4'(busyWrite && fifoReady) - 4'(popWord);
        full_d = (fill_d == 4'(`BUSY_DEPTH)); // [RULE15]
        case (state_q)
            COLLECT:
            begin
                if (popWord)
                begin
                    holdWord_d = {fifoData, holdWord_q[`UPLINK_BITS-1:`BUSY_WIDTH]};
                    count_d = count_q + 2'h1;
                    if (count_q == 2'(`UPLINK_WORDS - 1))
                    begin
                        count_d = 2'h0;
                        wait_d = '0;
                        over_d = 1'b0;
                        state_d = WAIT_SLOT; // [RULE11]
                    end
                end
            end
            WAIT_SLOT:
            begin
                // the word is held however long the slot takes
                if (wait_q < waitLimit)
                begin
                    wait_d = wait_q + 10'h1;
                end
                else
                begin
                    over_d = 1'b1; // [RULE12]
                end
                if (slotSeen)
                begin
                    reqTog_d = ~reqTog_q;
                    state_d = SENDING;
                end
            end
            SENDING:
            begin
                if (ackSeen)
                begin
                    state_d = COLLECT;
                end
            end
            default:
            begin
                state_d = COLLECT;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= COLLECT;
            count_q <= '0;
            holdWord_q <= '0;
            reqTog_q <= 1'b0;
            wait_q <= '0;
            over_q <= 1'b0;
            full_q <= 1'b0;
            fill_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            count_q <= count_d;
            holdWord_q <= holdWord_d;
            reqTog_q <= reqTog_d;
            wait_q <= wait_d;
            over_q <= over_d;
            full_q <= full_d;
            fill_q <= fill_d;
        end
    end

    assign busyFull = full_q;
    assign slotOverdue = over_q;

    a_valid_follows_frame: assert property (@(posedge clock) disable iff (srst)
        newFrame |=> trigValid) else $error("frame not strobed"); // [RULE14]
    a_valid_single_pulse: assert property (@(posedge clock) disable iff (srst)
        trigValid |=> !trigValid) else $error("valid longer than one cycle"); // [RULE14]
    a_spare_bits_zero: assert property (@(posedge clock) disable iff (srst)
        trigValid |-> trigInfo.triggerTypeWord[15:9] == 7'h00) else $error("spare bits"); // [RULE9]
    a_fields_together: assert property (@(posedge clock) disable iff (srst)
        newFrame |=> trigInfo == {$past(linkInfo_q.triggerTypeWord) & 16'h01ff,
        $past(linkInfo_q.bunchCrossingId), $past(linkInfo_q.orbitCount)})
        else $error("fields not from one frame"); // [RULE16]
    a_flag_mapping: assert property (@(posedge clock) disable iff (srst)
        trigValid |-> trigFlags.moduleTransferTrigger == trigInfo.triggerTypeWord[8]
        && trigFlags.orbitMarker == trigInfo.triggerTypeWord[0]) else $error("flag map"); // [RULE6]
    a_run_start: assert property (@(posedge clock) disable iff (srst)
        trigValid && trigFlags.triggeredRunFlag |-> triggeredRun == trigFlags.startEnd)
        else $error("triggered run state"); // [RULE7]
    a_cont_start: assert property (@(posedge clock) disable iff (srst)
        trigValid && trigFlags.continuousRunFlag |-> continuousRun == trigFlags.startEnd)
        else $error("continuous run state"); // [RULE8]
    a_drop_at_boundary: assert property (@(posedge clock) disable iff (srst)
        $changed(hbfDrop) |-> $past(newFrame)) else $error("drop mid frame"); // [RULE13]
    a_hold_while_wait: assert property (@(posedge clock) disable iff (srst)
        state_q != COLLECT |=> $stable(holdWord_q)) else $error("held word changed"); // [RULE12]
    a_overdue_time: assert property (@(posedge clock) disable iff (srst)
        state_q == WAIT_SLOT && wait_q == waitLimit |=> slotOverdue || state_q != WAIT_SLOT)
        else $error("overdue not flagged"); // [RULE12]
    a_word_count: assert property (@(posedge clock) disable iff (srst)
        $rose(state_q == WAIT_SLOT) |-> $past(popWord) && $past(count_q) == 2'h2)
        else $error("payload not three words"); // [RULE11]
endmodule : trigger_frame_decoder

/* File: verif/local_trigger_unit_model.sv */
`timescale 1ns/10ps
module local_trigger_unit_model
(
    input wire logic linkClock,
    input wire logic linkRst,
    input wire logic [15:0] typeWord,
    input wire logic [15:0] bcField,
    input wire logic [31:0] orbitValue,
    input wire logic skipFrame,
    input wire logic slotTog,
    output logic frameValid,
    output logic [159:0] framePayload,
    output logic uplinkSlot
);
    logic [95:0] filler_q;
    logic slotSeen_q;
    // one frame per bunch clock, back to back; skipFrame only for the gap test
    always_ff @(posedge linkClock)
    begin
        if (linkRst || skipFrame)
        begin
            frameValid <= 1'b0;
            // no frame: payload lines show the inverse, so a second skip in a row shows the stale data again
            framePayload <= linkRst ? '0 : ~framePayload;
        end
        else
        begin
            frameValid <= 1'b1;
            framePayload <= {filler_q, orbitValue, bcField, typeWord};
        end
        filler_q <= linkRst ? '0 : filler_q + 96'h1;
    end
    // slot turn as a one-cycle pulse on each toggle of the request
    always_ff @(posedge linkClock)
    begin
        slotSeen_q <= slotTog;
        uplinkSlot <= !linkRst && (slotTog != slotSeen_q);
    end
endmodule : local_trigger_unit_model

/* File: verif/trigger_frame_decoder_test.sv */
`timescale 1ns/10ps
module trigger_frame_decoder_test
    import trigger_frame_pkg::*;
;
    logic clock, srst, linkClock, linkRst, frameValid, uplinkSlot, uplinkLoad, frameGap;
    logic trigValid, triggeredRun, continuousRun, dropRequest, hbfDrop, receivers32;
    logic busyWrite, busyFull, slotOverdue, skipFrame, slotTog;
    logic [159:0] framePayload;
    logic [47:0] uplinkWord;
    logic [15:0] busyData, typeWord, bcField;
    logic [31:0] orbitValue;
    trigger_info_type trigInfo;
    trigger_flags_type trigFlags;
    int err_total = 0;
    int compares = 0;
    // low nibble: {dropRequest, triggeredRun, continuousRun, hbfDrop}
    // drop kept set on the step after a drop: frames without a heartbeat flag leave it as it was
    logic [19:0] runTab [9] = '{20'h00604, 20'h00a06, 20'h00402, 20'h0002b,
        20'h0000b, 20'h00022, 20'h00043, 20'h00801, 20'h00028};

    trigger_frame_decoder trigger_frame_decoder_i (.clock(clock), .srst(srst),
        .linkClock(linkClock), .linkRst(linkRst), .frameValid(frameValid),
        .framePayload(framePayload), .uplinkSlot(uplinkSlot), .uplinkWord(uplinkWord),
        .uplinkLoad(uplinkLoad), .frameGap(frameGap), .trigValid(trigValid),
        .trigInfo(trigInfo), .trigFlags(trigFlags), .triggeredRun(triggeredRun),
        .continuousRun(continuousRun), .dropRequest(dropRequest), .hbfDrop(hbfDrop),
        .receivers32(receivers32), .busyWrite(busyWrite), .busyData(busyData),
        .busyFull(busyFull), .slotOverdue(slotOverdue));
    local_trigger_unit_model local_trigger_unit_model_i (.linkClock(linkClock),
        .linkRst(linkRst), .typeWord(typeWord), .bcField(bcField),
        .orbitValue(orbitValue), .skipFrame(skipFrame), .slotTog(slotTog),
        .frameValid(frameValid), .framePayload(framePayload), .uplinkSlot(uplinkSlot));

    always #4 clock = ~clock;
    // bunch clock phase offset so edges never line up with the system clock
    initial
    begin
        linkClock = 1'b0;
        #3.7;
        forever #16 linkClock = ~linkClock;
    end

    task complete_run();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function logic [8:0] rev9(input logic [8:0] v);
        for (int i = 0; i < 9; i++)
            rev9[8-i] = v[i];
    endfunction : rev9

    // trigValid stands one cycle, so it is looked at on every falling edge
    task wait_trig();
        int n;
        n = 0;
        @(negedge clock);
        while (trigValid !== 1'b1 && n < 100)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 100)
            chk(64'h0, 64'h1);
    endtask : wait_trig

    // frames repeat, so the third strobe surely carries the new fields
    task send(input logic [15:0] tt, input logic [11:0] bc, input logic [31:0] orb);
        @(posedge clock);
        typeWord <= tt;
        bcField <= {4'ha, bc};
        orbitValue <= orb;
        repeat (3) wait_trig();
    endtask : send

    task slot_take(input logic [47:0] exp);
        int n;
        n = 0;
        @(posedge clock);
        slotTog <= ~slotTog;
        @(negedge linkClock);
        while (uplinkLoad !== 1'b1 && n < 200)
        begin
            @(negedge linkClock);
            n++;
        end
        if (n >= 200)
            chk(64'h0, 64'h1);
        chk(64'(uplinkWord), 64'(exp));
    endtask : slot_take

    task put(input logic [15:0] base, input int cnt);
        for (int i = 0; i < cnt; i++)
        begin
            @(posedge clock);
            busyWrite <= 1'b1;
            busyData <= base + 16'(i);
        end
        @(posedge clock);
        busyWrite <= 1'b0;
    endtask : put

    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        complete_run();
    end

    initial
    begin
        clock = 1'b0;
        srst = 1'b1;
        linkRst = 1'b1;
        {dropRequest, receivers32, busyWrite, skipFrame, slotTog} = '0;
        busyData = '0;
        typeWord = '0;
        bcField = '0;
        orbitValue = '0;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        // the link reset needs two bunch clock edges
        repeat (4) @(posedge clock);
        linkRst <= 1'b0;
        for (int k = 0; k < 9; k++)
        begin
            send(16'hfe00 | (16'h1 << k), 12'hfff - 12'(k), 32'hffff_fffe - 32'(k));
            chk(64'(trigInfo.triggerTypeWord), 64'(16'h1 << k));
            chk(64'(trigInfo.bunchCrossingId), 64'(12'hfff - 12'(k)));
            chk(64'(trigInfo.orbitCount), 64'(32'hffff_fffe - 32'(k)));
            chk(64'(trigFlags), 64'(rev9(9'(16'h1 << k))));
        end
        $display("test decode done");
        foreach (runTab[i])
        begin
            @(posedge clock);
            dropRequest <= runTab[i][3];
            send(runTab[i][19:4], 12'h123, 32'h89ab_cdef);
            chk(64'(triggeredRun), 64'(runTab[i][2]));
            chk(64'(continuousRun), 64'(runTab[i][1]));
            chk(64'(hbfDrop), 64'(runTab[i][0]));
        end
        $display("test run state done");
        @(posedge clock);
        receivers32 <= 1'b1;
        put(16'h1000, 3);
        repeat (10) @(posedge clock);
        put(16'h2000, 8);
        repeat (2) @(posedge clock);
        chk(64'(busyFull), 64'h1);
        put(16'hdead, 1);
        repeat (440) @(posedge clock);
        chk(64'(slotOverdue), 64'h0);
        repeat (60) @(posedge clock);
        chk(64'(slotOverdue), 64'h1);
        slot_take({16'h1002, 16'h1001, 16'h1000});
        repeat (20) @(posedge clock);
        chk(64'(busyFull), 64'h0);
        slot_take({16'h2002, 16'h2001, 16'h2000});
        slot_take({16'h2005, 16'h2004, 16'h2003});
        put(16'h3000, 1);
        // the refused word must never show up in the stream
        slot_take({16'h3000, 16'h2007, 16'h2006});
        $display("test uplink done");
        chk(64'(frameGap), 64'h0);
        @(posedge clock);
        skipFrame <= 1'b1;
        repeat (5) @(posedge clock);
        skipFrame <= 1'b0;
        repeat (20) @(posedge clock);
        chk(64'(frameGap), 64'h1);
        $display("test frame gap done");
        complete_run();
    end
endmodule : trigger_frame_decoder_test
